//--- logic/vcrcs_top.sv
// VC resource control and status register bank with table load control.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module vcrcs_top
  import vcrcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Port role: high on the upstream port, held static.
  input wire logic is_upstream,
  // Wishbone slave port.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Table and link events.
  input wire logic table_write,
  input vcrcs_link_t link,
  // Towards the port arbiter.
  output logic [7:0] traffic_class_map,
  output logic [2:0] arbitration_select,
  output logic table_load_stb,
  output logic [7:0] arbitration_capability
);

  ////////////////////////////////////////////////////////////////////////////////

  vcrcs_req_t req;
  logic ack_w;
  logic seq_busy;
  logic seq_done;
  logic seq_copy;
  logic load_go;
  logic [7:0] tcmap_q;
  logic [2:0] sel_q;
  logic tstat_q;
  logic neg_q;
  logic fc2_q;
  logic [31:0] rdata_q;
  logic [31:0] ctrl_v;
  logic [31:0] stat_v;
  logic [31:0] wmerged;
  logic [7:0] cap_v;
  logic uses_table;
  logic [2:0] wsel;
  logic ctrl_wr;
  logic copy_q;

  // Bus front end.
  vcrcs_wb_slave u_wb (
    .clk(clk),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(ack_w),
    .req(req)
  );

  // Table copy sequencer.
  vcrcs_load_seq u_seq (
    .clk(clk),
    .nrst(nrst),
    .start(load_go),
    .busy(seq_busy),
    .done(seq_done),
    .copy_stb(seq_copy)
  );

  ////////////////////////////////////////////////////////////////////////////////

  assign cap_v = is_upstream ? VCRCS_CAP_UP : VCRCS_CAP_DOWN;

  assign ctrl_wr = req.wr && (req.addr == VCRCS_CTRL_OFF);
  assign wmerged = vcrcs_merge(ctrl_v, req.data, req.sel);

  // Scheme as it stands after this write, so one write may select and load.
  assign wsel = wmerged[VCRCS_SEL_MSB:VCRCS_SEL_LSB];

  // Selected scheme uses the table when it is nonzero and its bit is set in cap_v for this port role.
  assign uses_table = (wsel != 3'h0) && cap_v[wsel];

  // load start gating
  // A one in the load bit on the upstream port with a table scheme starts a copy.
  assign load_go = ctrl_wr && req.sel[2] && req.data[VCRCS_LOAD_BIT] && is_upstream
                   && uses_table && !seq_busy;

  // Control register image as read back.
  always_comb begin
    ctrl_v = 32'h0;
    ctrl_v[VCRCS_TCMAP_MSB:VCRCS_TCMAP_LSB] = tcmap_q;
    ctrl_v[VCRCS_LOAD_BIT] = 1'b0;
    ctrl_v[VCRCS_SEL_MSB:VCRCS_SEL_LSB] = sel_q;
    ctrl_v[VCRCS_CHID_MSB:VCRCS_CHID_LSB] = VCRCS_CHID_VAL;
    ctrl_v[VCRCS_CHEN_BIT] = VCRCS_CHEN_VAL;
  end

  // Status register image; every other bit stays zero.
  always_comb begin
    stat_v = 32'h0;
    stat_v[VCRCS_TSTAT_BIT] = tstat_q && is_upstream;
    stat_v[VCRCS_NEG_BIT] = neg_q && link.dl_active && VCRCS_CHEN_VAL;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Traffic class map: bit 0 keeps its reset value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tcmap_q <= VCRCS_TCMAP_RST;
    end else if (ctrl_wr) begin
      tcmap_q <= {wmerged[VCRCS_TCMAP_MSB:1], VCRCS_TCMAP_RST[0]};
    end
  end

  // Arbitration select is stored as written; software keeps it legal.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= VCRCS_SEL_RST;
    end else if (ctrl_wr) begin
      sel_q <= wsel;
    end
  end

  // Table status: a table write wins over completion of a running copy.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tstat_q <= 1'b0;
    end else if (table_write && is_upstream) begin
      tstat_q <= 1'b1;
    end else if (seq_done) begin
      tstat_q <= 1'b0;
    end
  end

  // Negotiation pending: set while the link is not active, cleared when the second init state ends.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fc2_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      fc2_q <= link.fc_init2;
      if (!link.dl_active) begin
        neg_q <= 1'b1;
      end else if (fc2_q && !link.fc_init2) begin
        neg_q <= 1'b0;
      end
    end
  end

  // Read data register; unmapped reads return zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0;
    end else if (req.rd) begin
      unique case (req.addr)
        VCRCS_CTRL_OFF: rdata_q <= ctrl_v;
        VCRCS_STAT_OFF: rdata_q <= stat_v;
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  // Copy strobe registered for the arbiter, which skips invalid entries itself.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      copy_q <= 1'b0;
    end else begin
      copy_q <= seq_copy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Outputs.
  assign wb_ack_o = ack_w;
  assign wb_dat_o = rdata_q;
  assign traffic_class_map = tcmap_q;
  assign arbitration_select = sel_q;
  assign table_load_stb = copy_q;
  assign arbitration_capability = cap_v;

endmodule : vcrcs_top

//--- logic/vcrcs_pkg.sv
// Package with register map, field layout and types of the VC resource control block.
package vcrcs_pkg;

  // Register byte offsets.
  localparam logic [11:0] VCRCS_CTRL_OFF = 12'h214;
  localparam logic [11:0] VCRCS_STAT_OFF = 12'h218;

  // Control register field positions.
  localparam int VCRCS_TCMAP_LSB = 0;
  localparam int VCRCS_TCMAP_MSB = 7;
  localparam int VCRCS_LOAD_BIT = 16;
  localparam int VCRCS_SEL_LSB = 17;
  localparam int VCRCS_SEL_MSB = 19;
  localparam int VCRCS_CHID_LSB = 24;
  localparam int VCRCS_CHID_MSB = 26;
  localparam int VCRCS_CHEN_BIT = 31;

  // Status register field positions.
  localparam int VCRCS_TSTAT_BIT = 16;
  localparam int VCRCS_NEG_BIT = 17;

  // Values after reset and fixed field values.
  localparam logic [7:0] VCRCS_TCMAP_RST = 8'hff;
  localparam logic [2:0] VCRCS_SEL_RST = 3'h0;
  localparam logic [2:0] VCRCS_CHID_VAL = 3'h0;
  localparam logic VCRCS_CHEN_VAL = 1'b1;
  localparam logic [7:0] VCRCS_CAP_UP = 8'h03;
  localparam logic [7:0] VCRCS_CAP_DOWN = 8'h01;

  // Cycles the table copy into the arbiter takes, one per table word.
  localparam logic [3:0] VCRCS_LOAD_CYCLES = 4'h8;

  // Bus request carried from the bus front end to the register bank.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] sel;
  } vcrcs_req_t;

  // Link state reported by the data link layer.
  typedef struct packed {
    logic dl_active;
    logic fc_init2;
  } vcrcs_link_t;

  // Returns the merged byte-enabled value of a register write.
  function automatic logic [31:0] vcrcs_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : vcrcs_merge

endpackage : vcrcs_pkg

//--- logic/vcrcs_wb_slave.sv
// Classic Wishbone slave front end that turns bus cycles into single-cycle requests.
`timescale 1ns/1ps
module vcrcs_wb_slave
  import vcrcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave port.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  // Request towards the register bank.
  output vcrcs_req_t req
);

  logic ack_q;

  // Ack one cycle after the strobe, then drop it so each access is acked once.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  // The request acts in the cycle of the ack edge only.
  always_comb begin
    req.wr = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
    req.rd = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;
    req.addr = {wb_adr_i[11:2], 2'b00};
    req.data = wb_dat_i;
    req.sel = wb_sel_i;
  end

  assign wb_ack_o = ack_q;

endmodule : vcrcs_wb_slave

//--- logic/vcrcs_load_seq.sv
// Sequencer that copies the arbitration table into the arbiter on request.
`timescale 1ns/1ps
module vcrcs_load_seq
  import vcrcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Start pulse and progress.
  input wire logic start,
  output logic busy,
  output logic done,
  // Copy strobe towards the arbiter.
  output logic copy_stb
);

  typedef enum logic [1:0] {
    VCRCS_IDLE = 2'b00,
    VCRCS_COPY = 2'b01,
    VCRCS_DONE = 2'b11
  } vcrcs_seq_t;

  vcrcs_seq_t state_q;
  logic [3:0] cnt_q;

  // Walk one table word per cycle, then report completion for one cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= VCRCS_IDLE;
      cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        VCRCS_IDLE: begin
          if (start) begin
            state_q <= VCRCS_COPY;
            cnt_q <= VCRCS_LOAD_CYCLES - 4'h1;
          end
        end
        VCRCS_COPY: begin
          if (cnt_q == 4'h0) begin
            state_q <= VCRCS_DONE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        VCRCS_DONE: begin
          state_q <= VCRCS_IDLE;
        end
        default: begin
          state_q <= VCRCS_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_q != VCRCS_IDLE);
  assign done = (state_q == VCRCS_DONE);
  assign copy_stb = (state_q == VCRCS_COPY);

endmodule : vcrcs_load_seq

//--- tb/vcrcs_top_chk.sv
// Concurrent checks on the ports of the VC resource register bank.
`timescale 1ns/1ps
module vcrcs_top_chk
  import vcrcs_pkg::*;
(
  // Clock, reset and port role.
  input wire logic clk,
  input wire logic nrst,
  input wire logic is_upstream,
  // Bus side.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Arbiter side.
  input wire logic [7:0] traffic_class_map,
  input wire logic [2:0] arbitration_select,
  input wire logic table_load_stb,
  input wire logic [7:0] arbitration_capability
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic acc;
  logic rd_ctl;
  logic rd_sts;
  logic ld_wr;
  // Decode of the access answered in this cycle.
  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign rd_ctl = acc && !wb_we_i && wb_adr_i == VCRCS_CTRL_OFF;
  assign rd_sts = acc && !wb_we_i && wb_adr_i == VCRCS_STAT_OFF;
  assign ld_wr = acc && wb_we_i && wb_adr_i == VCRCS_CTRL_OFF && wb_sel_i[2] && wb_dat_i[16]
    && wb_dat_i[19:17] == 3'h1 && is_upstream && !table_load_stb;
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_cap_role: assert property (arbitration_capability == (is_upstream ? 8'h03 : 8'h01))
    else $error("capability does not match port role");
  chk_map_lsb: assert property (traffic_class_map[0])
    else $error("map bit zero not set");
  chk_ctl_read: assert property (rd_ctl |-> wb_dat_o ==
    {8'h80, 4'h0, arbitration_select, 1'b0, 8'h00, traffic_class_map})
    else $error("control read value wrong");
  chk_sts_read: assert property (rd_sts |-> wb_dat_o[31:18] == 14'h0000 &&
    wb_dat_o[15:0] == 16'h0000 && (is_upstream || !wb_dat_o[16]))
    else $error("status read value wrong");
  chk_load_len: assert property ($rose(table_load_stb) |-> table_load_stb[*8] ##1 !table_load_stb)
    else $error("table copy strobe length wrong");
  chk_load_gate: assert property ($rose(table_load_stb) |-> is_upstream && arbitration_select == 3'h1)
    else $error("table copy started without a table scheme upstream");
  chk_load_start: assert property (ld_wr |-> ##[1:3] table_load_stb)
    else $error("table copy not started after load write");
endmodule : vcrcs_top_chk
bind vcrcs_top vcrcs_top_chk vcrcs_top_chk_i (.clk(clk), .nrst(nrst), .is_upstream(is_upstream),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .traffic_class_map(traffic_class_map), .arbitration_select(arbitration_select),
  .table_load_stb(table_load_stb), .arbitration_capability(arbitration_capability));

//--- tb/tb_vcrcs_top.sv
// Self-checking bench for the VC resource register bank.
`timescale 1ns/1ps
module tb_vcrcs_top;
  import vcrcs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic is_upstream = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic ack;
  logic [31:0] rdat;
  logic table_write = 1'b0;
  vcrcs_link_t link = '0;
  logic [7:0] map;
  logic [2:0] asel;
  logic ld_stb;
  logic [7:0] cap;
  logic [31:0] r;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int ld_cnt = 0;
  vcrcs_top vcrcs_top_i (.clk(clk), .nrst(nrst), .is_upstream(is_upstream), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_ack_o(ack), .wb_dat_o(rdat), .table_write(table_write), .link(link),
    .traffic_class_map(map), .arbitration_select(asel), .table_load_stb(ld_stb),
    .arbitration_capability(cap));
  // Clock, timeout and copy strobe counting.
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (ld_stb === 1'b1) ld_cnt++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // One classic bus cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) check("ack", 32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset
  task automatic tbl_wr();
    @(posedge clk);
    table_write <= 1'b1;
    @(posedge clk);
    table_write <= 1'b0;
  endtask : tbl_wr
  // Reset values, read-only and reserved fields, unmapped place.
  task automatic t_fields();
    check("cap", {24'h0, cap}, 32'h3);
    bus(0, VCRCS_CTRL_OFF, 0, r);
    check("ctl_rst", r, 32'h800000ff);
    bus(1, VCRCS_STAT_OFF, 32'hffffffff, r);
    bus(0, VCRCS_STAT_OFF, 0, r);
    check("sts_rst", r, 32'h0);
    bus(1, VCRCS_CTRL_OFF, 32'h7ff0ff00, r);
    bus(0, VCRCS_CTRL_OFF, 0, r);
    check("ctl_ro", r, 32'h80000001);
    bus(1, 12'h21c, 32'h12345678, r);
    bus(0, 12'h21c, 0, r);
    check("unmapped", r, 32'h0);
  endtask : t_fields
  // Table status set by a table write, cleared by a load.
  task automatic t_load();
    tbl_wr();
    bus(0, VCRCS_STAT_OFF, 0, r);
    check("sts_set", r, 32'h00010000);
    bus(1, VCRCS_CTRL_OFF, 32'h000100ff, r);
    repeat (14) @(posedge clk);
    check("no_tbl_scheme", ld_cnt, 0);
    bus(1, VCRCS_CTRL_OFF, 32'h000300ff, r);
    bus(0, VCRCS_CTRL_OFF, 0, r);
    check("ld_rd0", r, 32'h800200ff);
    repeat (14) @(posedge clk);
    check("ld_len", ld_cnt, 8);
    bus(0, VCRCS_STAT_OFF, 0, r);
    check("sts_clr", r, 32'h0);
    bus(1, VCRCS_CTRL_OFF, 32'h000200ff, r);
    repeat (14) @(posedge clk);
    check("ld_zero", ld_cnt, 8);
  endtask : t_load
  // Negotiation pending follows the link state.
  task automatic t_neg();
    link <= '{dl_active: 1'b1, fc_init2: 1'b1};
    bus(0, VCRCS_STAT_OFF, 0, r);
    check("neg_set", r, 32'h00020000);
    link <= '{dl_active: 1'b1, fc_init2: 1'b0};
    repeat (3) @(posedge clk);
    bus(0, VCRCS_STAT_OFF, 0, r);
    check("neg_clr", r, 32'h0);
  endtask : t_neg
  // Downstream role: no status, no load.
  task automatic t_down();
    is_upstream <= 1'b0;
    link <= '0;
    do_reset();
    check("cap_dn", {24'h0, cap}, 32'h1);
    tbl_wr();
    bus(0, VCRCS_STAT_OFF, 0, r);
    check("sts_dn", r, 32'h0);
    // downstream software selects only fixed round robin.
    bus(1, VCRCS_CTRL_OFF, 32'h000100ff, r);
    repeat (14) @(posedge clk);
    check("ld_dn", ld_cnt, 8);
  endtask : t_down
  initial begin
    do_reset();
    t_fields();
    t_load();
    t_neg();
    t_down();
    summarize();
  end
endmodule : tb_vcrcs_top
